/* include/mbc_pkg.sv */
// Constants shared by the multiplexed bus controller and its helpers.
// Assumes a 32-bit processor-side request port and an AXI4-Lite register bus.
package mbc_pkg;
    localparam logic [31:0] ADDR_FAULT = 32'hFFFF_E208;
    localparam logic [31:0] ADDR_CTRL = 32'hFFFF_E20C;
    localparam logic [31:0] ADDR_STATUS = 32'hFFFF_E210;
    localparam logic [31:0] FAULT_RESET = 32'h0000_0000;
    localparam int CTRL_OVR_BIT = 0;
    localparam int CTRL_W_LSB = 1;
    localparam int STAT_SEEN_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam logic [1:0] W8 = 2'h0;
    localparam logic [1:0] W16 = 2'h1;
    localparam logic [1:0] W32 = 2'h2;
    localparam logic [3:0] SIZE_BLOCK = 4'h0;
    localparam logic [4:0] BLOCK_BYTES = 5'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int SYNC_W = 36;
    localparam logic [1:0] STRAP_WAIT = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ADDR = 3'b010,
        ST_DATA = 3'b100
    } mbc_state_t;
endpackage

/* include/mbc_sync_if.sv */
// Carries pin-side levels into the two-flop synchroniser and back.
// Assumes all members of raw come from outside the clk_sys_i domain.
`timescale 1ns/1ps
interface mbc_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport user (output raw, input sync);
    modport sync_side (input raw, output sync);
endinterface

/* logic/mbc_sync.sv */
// Two-flop synchroniser for pin inputs.
// Assumes one clock; the first stage is read by the second stage only.
`timescale 1ns/1ps
module mbc_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    mbc_sync_if.sync_side s
);
    logic [W-1:0] meta;
    logic [W-1:0] stage;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta <= '1;
            stage <= '1;
        end else begin
            meta <= s.raw;
            stage <= meta;
        end
    end

    assign s.sync = stage;
endmodule // mbc_sync

/* logic/mbc_bus_ctrl.sv */
// Address, read and write control of the multiplexed system bus, plus registers.
// Assumes one 200 MHz clock, pin inputs unsynchronised, one request at a time.
// Notes on behaviour
// - Read-only register holds address of transfer that caused latest bus fault.
// - Writes to fault register change nothing; value reads zero before first fault.
// - Address phase drives address on shared lines, bit 31 is address MSB.
// - Low four lines carry size code: 0 block, 1..4 bytes.
// - Low address lines follow current word/byte; block reads subblock, other transfers sequential.
// - Width code out: 00 eight, 01 sixteen, 10 thirty-two bits.
// - Instruction/data qualifier high for instruction, low for data, whole cycle.
// - Separate active-low read and write strobes mark the transaction kind.
// - Data phase enable low from first data cycle to end of last.
// - Four active-low lane enables; all used on a 32-bit port.
// - 16-bit: high, 1, A1, low; 8-bit: 1, 1, A1, A0.
// - Single reads, split reads and cache block reads at every width.
// - Refill requests four words, presenting address of the wanted word.
// - Subblock order: target, its doubleword partner, then other doubleword alike.
// - Refill from 16-bit port is eight halfwords in subblock order.
// - Writes are single (short bursts on narrow ports) or line writebacks.
// - Line writeback runs subblock order starting at word zero.
// - After reset every region uses boot width until software reprograms.
// - Bus fault ignored after first data accepted; only earlier faults captured.
`timescale 1ns/1ps
module mbc_bus_ctrl (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic req_write_i,
    input wire logic req_instr_i,
    input wire logic req_block_i,
    input wire logic [31:0] req_addr_i,
    input wire logic [2:0] req_bytes_i,
    input wire logic [127:0] req_wdata_i,
    output logic rd_valid_o,
    output logic [31:0] rd_data_o,
    output logic [3:0] rd_lo_o,
    output logic done_o,
    output logic fault_o,
    input wire logic [1:0] boot_width_i,
    output logic [31:0] ad_o,
    output logic ad_oe_n_o,
    input wire logic [31:0] ad_i,
    input wire logic ack_n_i,
    input wire logic bus_fault_n_i,
    output logic [3:0] addr_low_o,
    output logic ale_o,
    output logic [1:0] width_o,
    output logic cycle_active_n_o,
    output logic instr_data_o,
    output logic read_n_o,
    output logic write_n_o,
    output logic data_direction_o,
    output logic data_phase_n_o,
    output logic [3:0] byte_lane_enable_n_o,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    mbc_sync_if #(.W(mbc_pkg::SYNC_W)) sif ();
    assign sif.raw = {boot_width_i, bus_fault_n_i, ack_n_i, ad_i};
    mbc_sync #(.W(mbc_pkg::SYNC_W)) u_sync (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .s(sif));
    logic [31:0] ad_s;
    logic ack_s;
    logic fault_s;
    logic [1:0] strap_s;
    assign ad_s = sif.sync[31:0];
    assign ack_s = !sif.sync[32];
    assign fault_s = !sif.sync[33];
    assign strap_s = sif.sync[35:34];

    mbc_pkg::mbc_state_t state, next_state;
    logic [31:0] addr, next_addr;
    logic [127:0] wdata, next_wdata;
    logic is_write, next_is_write, is_instr, next_is_instr, is_block, next_is_block;
    logic [1:0] cur_w, next_cur_w;
    logic [3:0] cur_lo, next_cur_lo, start_unit, next_start_unit, k, next_k;
    logic [4:0] left, next_left, taken;
    logic first_taken, next_first_taken;
    logic [31:0] next_ad;
    logic next_rd_valid, next_done, next_fault;
    logic [31:0] next_rd_data;
    logic [3:0] next_rd_lo;
    logic [31:0] fault_addr, next_fault_addr;
    logic fault_seen, next_fault_seen;
    logic [1:0] boot_w, next_boot_w, strap_cnt, next_strap_cnt;
    logic strap_done, next_strap_done;
    logic ovr, next_ovr;
    logic [1:0] ovr_w, next_ovr_w;
    logic [1:0] eff_w, sh;
    logic [3:0] unit_next, be_en;
    logic capture;

    function automatic logic [31:0] lane_data(input logic [127:0] d, input logic [3:0] lo,
                                              input logic [1:0] w);
        logic [31:0] word;
        word = d[{lo[3:2], 5'h00} +: 32];
        if (w == mbc_pkg::W8) begin
            lane_data = word >> {lo[1:0], 3'h0};
        end else if (w == mbc_pkg::W16) begin
            lane_data = word >> {lo[1], 4'h0};
        end else begin
            lane_data = word;
        end
    endfunction

    // Reserved strap width falls back to full width; a reserved override code goes out unchanged on the width pins while beats run as 32-bit
    assign eff_w = ovr ? ovr_w : boot_w;
    assign sh = (cur_w == mbc_pkg::W8) ? 2'h0 : (cur_w == mbc_pkg::W16) ? 2'h1 : 2'h2;

    always_comb begin
        if (cur_w == mbc_pkg::W8) begin
            taken = 5'h01;
        end else if (cur_w == mbc_pkg::W16) begin
            taken = (cur_lo[0] || left < 5'h02) ? 5'h01 : 5'h02;
        end else begin
            taken = is_block ? 5'h04 : left;
        end
    end

    // Xor with the beat count gives target, partner, then the other doubleword
    assign unit_next = start_unit ^ (k + 4'h1);

    always_comb begin
        be_en = 4'h0;
        if (cur_w == mbc_pkg::W8) begin
            be_en = {2'b00, !cur_lo[1], !cur_lo[0]};
        end else if (cur_w == mbc_pkg::W16) begin
            be_en = {cur_lo[0] || taken == 5'h02, 1'b0, !cur_lo[1], !cur_lo[0]};
        end else if (is_block) begin
            be_en = 4'hF;
        end else begin
            unique case (left[2:0])
                3'h1: be_en = 4'h1 << cur_lo[1:0];
                3'h2: be_en = 4'h3 << cur_lo[1:0];
                3'h3: be_en = 4'h7 << cur_lo[1:0];
                default: be_en = 4'hF;
            endcase
        end
    end

    assign capture = (state == mbc_pkg::ST_DATA) && fault_s && !first_taken;

    always_comb begin
        next_state = state;
        next_addr = addr;
        next_wdata = wdata;
        next_is_write = is_write;
        next_is_instr = is_instr;
        next_is_block = is_block;
        next_cur_w = cur_w;
        next_cur_lo = cur_lo;
        next_start_unit = start_unit;
        next_k = k;
        next_left = left;
        next_first_taken = first_taken;
        next_ad = ad_o;
        next_rd_valid = 1'b0;
        next_rd_data = rd_data_o;
        next_rd_lo = rd_lo_o;
        next_done = 1'b0;
        next_fault = 1'b0;
        next_fault_addr = fault_addr;
        next_fault_seen = fault_seen;
        unique case (state)
            mbc_pkg::ST_IDLE: begin
                if (req_valid_i && req_ready_o) begin
                    next_state = mbc_pkg::ST_ADDR;
                    next_addr = req_addr_i;
                    next_wdata = req_wdata_i;
                    next_is_write = req_write_i;
                    next_is_instr = req_instr_i;
                    next_is_block = req_block_i;
                    next_cur_w = eff_w;
                    next_k = 4'h0;
                    next_first_taken = 1'b0;
                    next_left = req_block_i ? mbc_pkg::BLOCK_BYTES : {2'b00, req_bytes_i};
                    // Refill starts at the wanted word, writeback at word zero
                    if (req_block_i && !req_write_i) begin
                        next_start_unit = req_addr_i[3:0] >> ((eff_w == mbc_pkg::W8) ? 2'h0 :
                            (eff_w == mbc_pkg::W16) ? 2'h1 : 2'h2);
                    end else begin
                        next_start_unit = 4'h0;
                    end
                    next_cur_lo = req_block_i ? (req_write_i ? 4'h0 : req_addr_i[3:0]) :
                        req_addr_i[3:0];
                    next_ad = {req_addr_i[31:4],
                        req_block_i ? mbc_pkg::SIZE_BLOCK : {1'b0, req_bytes_i}};
                end
            end
            mbc_pkg::ST_ADDR: begin
                next_state = mbc_pkg::ST_DATA;
                next_ad = lane_data(wdata, cur_lo, cur_w);
            end
            default: begin
                if (capture) begin
                    // Fault beats an acknowledge seen in the same first data cycle
                    next_fault_addr = addr;
                    next_fault_seen = 1'b1;
                    next_fault = 1'b1;
                    next_state = mbc_pkg::ST_IDLE;
                end else if (ack_s) begin
                    next_first_taken = 1'b1;
                    if (!is_write) begin
                        next_rd_valid = 1'b1;
                        next_rd_data = ad_s;
                        next_rd_lo = cur_lo;
                    end
                    if (left == taken) begin
                        next_state = mbc_pkg::ST_IDLE;
                        next_done = 1'b1;
                    end else begin
                        next_left = left - taken;
                        next_k = k + 4'h1;
                        // Block beats step by unit, single beats by bytes moved
                        if (is_block) begin
                            next_cur_lo = 4'((unit_next << sh));
                        end else begin
                            next_cur_lo = cur_lo + taken[3:0];
                        end
                        next_ad = lane_data(wdata, next_cur_lo, cur_w);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= mbc_pkg::ST_IDLE;
            addr <= 32'h0000_0000;
            wdata <= 128'h0;
            is_write <= 1'b0;
            is_instr <= 1'b0;
            is_block <= 1'b0;
            cur_w <= mbc_pkg::W32;
            cur_lo <= 4'h0;
            start_unit <= 4'h0;
            k <= 4'h0;
            left <= 5'h00;
            first_taken <= 1'b0;
            ad_o <= 32'h0000_0000;
            rd_valid_o <= 1'b0;
            rd_data_o <= 32'h0000_0000;
            rd_lo_o <= 4'h0;
            done_o <= 1'b0;
            fault_o <= 1'b0;
            fault_addr <= mbc_pkg::FAULT_RESET;
            fault_seen <= 1'b0;
        end else begin
            state <= next_state;
            addr <= next_addr;
            wdata <= next_wdata;
            is_write <= next_is_write;
            is_instr <= next_is_instr;
            is_block <= next_is_block;
            cur_w <= next_cur_w;
            cur_lo <= next_cur_lo;
            start_unit <= next_start_unit;
            k <= next_k;
            left <= next_left;
            first_taken <= next_first_taken;
            ad_o <= next_ad;
            rd_valid_o <= next_rd_valid;
            rd_data_o <= next_rd_data;
            rd_lo_o <= next_rd_lo;
            done_o <= next_done;
            fault_o <= next_fault;
            fault_addr <= next_fault_addr;
            fault_seen <= next_fault_seen;
        end
    end

    // Pin outputs; the strap needs the synchroniser to settle before the first request
    assign req_ready_o = (state == mbc_pkg::ST_IDLE) && strap_done;
    assign ale_o = (state == mbc_pkg::ST_ADDR);
    assign cycle_active_n_o = (state == mbc_pkg::ST_IDLE);
    assign data_phase_n_o = (state != mbc_pkg::ST_DATA);
    assign read_n_o = (state == mbc_pkg::ST_IDLE) || is_write;
    assign write_n_o = (state == mbc_pkg::ST_IDLE) || !is_write;
    assign instr_data_o = (state != mbc_pkg::ST_IDLE) && is_instr;
    assign data_direction_o = (state != mbc_pkg::ST_DATA) || is_write;
    assign ad_oe_n_o = (state == mbc_pkg::ST_IDLE) || ((state == mbc_pkg::ST_DATA) && !is_write);
    assign width_o = (state == mbc_pkg::ST_IDLE) ? eff_w : cur_w;
    assign addr_low_o = cur_lo;
    assign byte_lane_enable_n_o = (state == mbc_pkg::ST_IDLE) ? 4'hF : ~be_en;

    // Register file
    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [31:0] aw_addr, next_aw_addr, w_data, next_w_data;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        next_ovr = ovr;
        next_ovr_w = ovr_w;
        next_boot_w = boot_w;
        next_strap_cnt = strap_cnt;
        next_strap_done = strap_done;
        if (!strap_done) begin
            next_strap_cnt = strap_cnt + 2'h1;
            if (strap_cnt == mbc_pkg::STRAP_WAIT) begin
                next_boot_w = (strap_s == 2'h3) ? mbc_pkg::W32 : strap_s;
                next_strap_done = 1'b1;
            end
        end
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
        end
        if (next_aw_held && next_w_held) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = mbc_pkg::RESP_OKAY;
            if (next_aw_addr == mbc_pkg::ADDR_CTRL) begin
                if (s_axi_wstrb[0]) begin
                    next_ovr = next_w_data[mbc_pkg::CTRL_OVR_BIT];
                    next_ovr_w = next_w_data[mbc_pkg::CTRL_W_LSB +: 2];
                end
            end else if (next_aw_addr != mbc_pkg::ADDR_FAULT &&
                         next_aw_addr != mbc_pkg::ADDR_STATUS) begin
                next_bresp = mbc_pkg::RESP_SLVERR;
            end
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = mbc_pkg::RESP_OKAY;
            next_rdata = 32'h0000_0000;
            unique case (s_axi_araddr)
                mbc_pkg::ADDR_FAULT: next_rdata = fault_addr;
                mbc_pkg::ADDR_CTRL: begin
                    next_rdata[mbc_pkg::CTRL_OVR_BIT] = ovr;
                    next_rdata[mbc_pkg::CTRL_W_LSB +: 2] = ovr_w;
                end
                mbc_pkg::ADDR_STATUS: begin
                    next_rdata[mbc_pkg::STAT_SEEN_BIT] = fault_seen;
                    next_rdata[mbc_pkg::STAT_BUSY_BIT] = (state != mbc_pkg::ST_IDLE);
                end
                default: next_rresp = mbc_pkg::RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 32'h0000_0000;
            w_data <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= mbc_pkg::RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= mbc_pkg::RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            ovr <= 1'b0;
            ovr_w <= mbc_pkg::W32;
            boot_w <= mbc_pkg::W32;
            strap_cnt <= 2'h0;
            strap_done <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
            ovr <= next_ovr;
            ovr_w <= next_ovr_w;
            boot_w <= next_boot_w;
            strap_cnt <= next_strap_cnt;
            strap_done <= next_strap_done;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    sequence addr_phase_s;
        ale_o && !cycle_active_n_o && !ad_oe_n_o;
    endsequence
    sequence first_data_s;
        !data_phase_n_o && !cycle_active_n_o;
    endsequence
    ale_phase_a: assert property (ale_o |-> addr_phase_s ##1 first_data_s)
        else $error("address phase not followed by data phase");
    size_code_a: assert property (ale_o |-> ad_o[3:0] == (is_block ? mbc_pkg::SIZE_BLOCK :
        {1'b0, left[2:0]}))
        else $error("size code wrong in address phase");
    strobe_kind_a: assert property (!cycle_active_n_o |-> (read_n_o ^ write_n_o))
        else $error("read and write strobes not exclusive");
    dir_read_a: assert property (!data_phase_n_o && !read_n_o |-> !data_direction_o)
        else $error("direction high while receiving");
    lanes_8bit_a: assert property (!cycle_active_n_o && cur_w == mbc_pkg::W8 |->
        byte_lane_enable_n_o == {2'b11, cur_lo[1:0]})
        else $error("8-bit lane enables wrong");
    fault_hold_a: assert property (!capture |=> $stable(fault_addr))
        else $error("fault address changed without a fault");
    fault_take_a: assert property (capture |=> fault_addr == $past(addr) && fault_o)
        else $error("fault address not captured");
    late_fault_a: assert property (first_taken && state == mbc_pkg::ST_DATA |=> !fault_o)
        else $error("fault taken after first data");
    cip_end_a: assert property (done_o |-> cycle_active_n_o && $past(ack_s))
        else $error("cycle ended without acknowledge");
endmodule // mbc_bus_ctrl

/* bench/mbc_agent.sv */
// Far-side memory agent: answers each data phase with an ack or a bus fault.
// Assumes the pin timing of mbc_bus_ctrl; read data carries its own beat address.
`timescale 1ns/1ps
module mbc_agent (
    input wire logic clk_i,
    input wire logic ale_i,
    input wire logic [31:0] ad_i,
    input wire logic [3:0] lo_i,
    input wire logic dphase_n_i,
    input wire logic rd_n_i,
    input wire logic err_i,
    output logic ack_n_o,
    output logic fault_n_o,
    output logic [31:0] ad_o
);
    logic [27:0] base = 28'h0;
    int gap = 0;
    initial {ack_n_o, fault_n_o, ad_o} = {2'h3, 32'h0};
    always @(posedge clk_i) begin
        if (ale_i) base <= ad_i[31:4];
        // Released lines toggle so a stale word can never look valid
        ad_o <= (!dphase_n_i && !rd_n_i) ? {base, lo_i} : ~ad_o;
        {ack_n_o, fault_n_o} <= 2'h3;
        if (gap > 0) gap <= gap - 1;
        else if (!dphase_n_i) begin
            // Each one-cycle ack pulse must clear the two-flop input path before the next one
            {ack_n_o, fault_n_o} <= err_i ? 2'h2 : 2'h1;
            gap <= 4 + $urandom_range(0, 2);
        end
    end
endmodule // mbc_agent

/* bench/tb_multiplexed_bus_address_rw_control.sv */
// Self-checking bench for mbc_bus_ctrl with mbc_agent on the bus pins.
// Assumes one clock; read beats are queued by the driver, checked by the monitor.
`timescale 1ns/1ps
module tb_multiplexed_bus_address_rw_control;
    logic clk_sys_i = 0, rstn_i = 0, req_valid_i = 0, req_write_i = 0, req_instr_i = 0;
    logic req_block_i = 0, ack_n_i, bus_fault_n_i, err = 0;
    logic [31:0] req_addr_i = 0, ad_i, s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
    logic [2:0] req_bytes_i = 3'h4;
    logic [127:0] req_wdata_i = 0;
    logic [127:0] wq;
    logic [1:0] boot_width_i = 0, bw = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic req_ready_o, rd_valid_o, done_o, fault_o, ad_oe_n_o, ale_o, cycle_active_n_o;
    logic instr_data_o, read_n_o, write_n_o, data_direction_o, data_phase_n_o;
    logic [31:0] rd_data_o, ad_o, s_axi_rdata;
    logic [3:0] rd_lo_o, addr_low_o, byte_lane_enable_n_o;
    logic [1:0] width_o, s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] exp_q[$];
    logic [31:0] e, a;
    int errors = 0, checks = 0, cycles = 0, ub = 1, w;
    always #2.5 clk_sys_i = ~clk_sys_i;
    mbc_bus_ctrl i_dut (.*);
    mbc_agent i_agent (.clk_i(clk_sys_i), .ale_i(ale_o), .ad_i(ad_o), .lo_i(addr_low_o),
        .dphase_n_i(data_phase_n_o), .rd_n_i(read_n_o), .err_i(err), .ack_n_o(ack_n_i),
        .fault_n_o(bus_fault_n_i), .ad_o(ad_i));
    task automatic check(input logic [39:0] s, input logic [39:0] x);
        checks++;
        if (s !== x) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, x);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic axi_wr(input logic [31:0] ad, input logic [31:0] d);
        bit aw = 0, wd = 0;
        @(posedge clk_sys_i);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {ad, d, 3'h7};
        while (!aw || !wd) begin
            @(negedge clk_sys_i);
            {aw, wd} = {aw | s_axi_awready, wd | s_axi_wready};
            @(posedge clk_sys_i);
            {s_axi_awvalid, s_axi_wvalid} <= {!aw, !wd};
        end
        do @(negedge clk_sys_i); while (s_axi_bvalid !== 1'h1);
        check(s_axi_bresp, mbc_pkg::RESP_OKAY);
        @(posedge clk_sys_i);
        s_axi_bready <= 1'h0;
    endtask
    task automatic axi_rd(input logic [31:0] ad, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk_sys_i);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {ad, 2'h3};
        do @(negedge clk_sys_i); while (s_axi_arready !== 1'h1);
        @(posedge clk_sys_i);
        s_axi_arvalid <= 1'h0;
        do @(negedge clk_sys_i); while (s_axi_rvalid !== 1'h1);
        check({s_axi_rresp, s_axi_rdata}, {r, d});
        @(posedge clk_sys_i);
        s_axi_rready <= 1'h0;
    endtask
    task automatic req(input logic wr, input logic blk, input logic [31:0] ad);
        logic f;
        for (int k = 0; k < (blk ? 16 : 4) / ub; k++)
            if (!wr && !err)
                exp_q.push_back({ad[31:4], blk ? 4'(((ad[3:0] / ub) ^ k) * ub) : 4'(ad[3:0] + k * ub)});
        @(posedge clk_sys_i);
        wq = {$urandom(), $urandom(), $urandom(), $urandom()};
        {req_valid_i, req_write_i, req_block_i, req_instr_i, req_addr_i} <= {1'h1, wr, blk, blk, ad};
        req_wdata_i <= wq;
        do @(negedge clk_sys_i); while (req_ready_o !== 1'h1);
        @(posedge clk_sys_i);
        req_valid_i <= 1'h0;
        @(negedge clk_sys_i);
        check({ale_o, cycle_active_n_o, read_n_o, write_n_o, instr_data_o, width_o, ad_o},
            {2'h2, wr, !wr, blk, bw, ad[31:4], blk ? mbc_pkg::SIZE_BLOCK : 4'h4});
        do @(negedge clk_sys_i); while (done_o !== 1'h1 && fault_o !== 1'h1);
        f = fault_o;
        // Last beat and done share a cycle; let the monitor pop it first
        @(posedge clk_sys_i);
        check({f, exp_q.size() == 0}, {err, 1'h1});
    endtask
    always @(negedge clk_sys_i) begin
        if (rd_valid_o === 1'h1) begin
            e = exp_q.size() ? exp_q.pop_front() : 32'hX;
            check({rd_lo_o, rd_data_o}, {e[3:0], e});
        end
        if (data_phase_n_o === 1'h0) begin
            check({cycle_active_n_o, data_direction_o, ad_oe_n_o}, {1'h0, read_n_o, !read_n_o});
            if (write_n_o === 1'h0)
                check(ad_o, wq[32 * addr_low_o[3:2] +: 32] >> 8 * addr_low_o[1:0]);
            if (bw == mbc_pkg::W8) check(byte_lane_enable_n_o, {2'h3, addr_low_o[1:0]});
            else if (bw == mbc_pkg::W16)
                check(byte_lane_enable_n_o[2:1], {1'h1, addr_low_o[1]});
            else check(byte_lane_enable_n_o, 4'h0);
        end
    end
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(50));
        for (w = 2; w >= 0; w--) begin
            @(posedge clk_sys_i);
            {rstn_i, bw, boot_width_i, ub} <= {1'h0, w[1:0], w[1:0], 1 << w};
            repeat (5) @(posedge clk_sys_i);
            rstn_i <= 1'h1;
            @(negedge clk_sys_i);
            check({cycle_active_n_o, byte_lane_enable_n_o}, 5'h1F);
            // Back-to-back line reads from random start words, then a writeback and a single read
            repeat (2) req(1'h0, 1'h1, {$urandom()} & ~32'h3);
            req(1'h1, 1'h1, {$urandom()} & ~32'hF);
            req(1'h0, 1'h0, {$urandom()} & ~32'h3);
        end
        {err, a} = {1'h1, {$urandom()} & ~32'h3};
        req(1'h0, 1'h0, a);
        err = 1'h0;
        axi_rd(mbc_pkg::ADDR_FAULT, a, mbc_pkg::RESP_OKAY);
        axi_wr(mbc_pkg::ADDR_FAULT, ~a);
        axi_rd(mbc_pkg::ADDR_FAULT, a, mbc_pkg::RESP_OKAY);
        axi_rd(32'hFFFF_E300, 32'h0, mbc_pkg::RESP_SLVERR);
        axi_rd(mbc_pkg::ADDR_STATUS, 32'h0000_0001, mbc_pkg::RESP_OKAY);
        axi_wr(mbc_pkg::ADDR_CTRL, 32'h0000_0005);
        axi_rd(mbc_pkg::ADDR_CTRL, 32'h0000_0005, mbc_pkg::RESP_OKAY);
        print_verdict();
    end
endmodule // tb_multiplexed_bus_address_rw_control
